//--- awb_pkg.sv
package awb_pkg;
  // register map, byte addresses on a 32-bit classic wishbone slave
  localparam logic [7:0] CH_BASE = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h40;
  localparam logic [7:0] STAT_ADDR = 8'h44;
  localparam int ADDR_W = 8;

  // control register fields
  localparam int CTRL_CYCLIC = 0;
  localparam int CTRL_CH16 = 1;
  localparam int CTRL_WB_EN = 2;
  localparam int CTRL_WB_ALL = 3;
  localparam int CTRL_LIVE_ZERO = 4;
  localparam int CTRL_RTD_TYPE = 5;
  localparam int CTRL_SUPPLY_SW7 = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h01;

  // status register fields
  localparam int STAT_ACT = 0;
  localparam int STAT_CH_LSB = 1;
  localparam int STAT_PEND_LSB = 16;

  // channel word layout
  localparam int WORD_W = 16;
  localparam int VAL_LSB = 3;
  localparam int VAL_W = 13;
  localparam int ACT_BIT = 2;
  localparam int ERR_BIT = 1;
  localparam int OV_BIT = 0;

  // live-zero range: 2048 units placed at 512..2560
  localparam logic [12:0] LIVE_OFFSET = 13'h0200;
  localparam logic [11:0] LIVE_SPAN = 12'h800;

  // module variants
  localparam logic [1:0] VAR_BASIC = 2'h0;
  localparam logic [1:0] VAR_EXTENDED = 2'h1;
  localparam logic [1:0] VAR_FAST = 2'h2;

  // timing
  localparam int CLK_NS = 50;
  localparam int TEST_NS = 1600000;
  localparam int TEST_CYC = TEST_NS / CLK_NS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TEST = 4'b0010,
    ST_CONV = 4'b0100,
    ST_STORE = 4'b1000
  } awb_state_t;
endpackage

//--- awb_sampler.sv
`timescale 1ns/1ps
// Summary of operation
// - 4-20 mA and 1-5 V ranges give codes 512 to 2560 for the span.
// - with open-wire test on, apply test current about 1.6 ms before converting.
// - test voltage over limit sets error bit 1 and stores value zero.
// - open-wire test covers 8 or 16 inputs, or 4 or 8 in 8-channel mode.
// - thermometer line breaks give zero; element/excitation error only on extended variant.
// - basic variant element break zeroes all thermometer channels with error clear.
// - overflow flag is kept per channel.
// - extended variant with switch 7 monitors excitation lines, flags breaks.
// - plain V/I channel lacking excitation jumper reports its value with error clear.
// - current/voltage switch setting ignores excitation breaks, error stays clear.
// - cyclic sampling converts every enabled channel in turn.
// - basic conversion time follows the input level, paced by the converter.
// - full scan time scales with channel count and converter time.
// - values sit in a circulating buffer, high byte then low byte, always readable.
// - fast variant does only cyclic sampling, no selective requests.
// - one write to a channel address requests conversion of that channel only.
// - module-wide activity flag is 1 while selective conversions are pending.
// - word layout: bits 15..3 value, 2 activity, 1 error, 0 overflow.
module awb_sampler import awb_pkg::*; #(
  parameter int NCH = 16,
  parameter logic [1:0] VARIANT = VAR_EXTENDED,
  parameter int TEST_CYCLES = TEST_CYC
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // converter front end
  output logic adc_start_o,
  output logic [3:0] adc_chan_o,
  output logic test_current_o,
  input wire logic adc_ready_i,
  input wire logic [11:0] adc_data_i,
  input wire logic adc_over_i,
  input wire logic test_over_limit_i,
  input wire logic [NCH-1:0] elem_break_i,
  input wire logic [NCH-1:0] exc_break_i,
  // module-wide activity
  output logic activity_o
);
  localparam int PIN_W = 16;

  // pin synchronisers; first stage feeds only the second
  logic [PIN_W-1:0] pin_a_q, pin_b_q;
  logic [NCH-1:0] elem_a_q, elem_b_q, exc_a_q, exc_b_q;
  always_ff @(posedge clk_i) begin
    pin_a_q <= {adc_ready_i, adc_over_i, test_over_limit_i, 1'b0, adc_data_i};
    pin_b_q <= pin_a_q;
    elem_a_q <= elem_break_i;
    elem_b_q <= elem_a_q;
    exc_a_q <= exc_break_i;
    exc_b_q <= exc_a_q;
  end
  logic rdy_s, ovr_s, lim_s;
  logic [11:0] data_s;
  assign rdy_s = pin_b_q[15];
  assign ovr_s = pin_b_q[14];
  assign lim_s = pin_b_q[13];
  assign data_s = pin_b_q[11:0];

  // control register
  logic [CTRL_W-1:0] ctrl_q;
  logic wb_hit, wb_wr, ch_hit;
  logic [3:0] ch_idx;
  assign wb_hit = cyc_i && stb_i && !ack_o;
  assign wb_wr = wb_hit && we_i;
  assign ch_hit = (adr_i < CH_BASE + 8'(4 * NCH)) && (adr_i[1:0] == 2'h0);
  assign ch_idx = 4'((adr_i - CH_BASE) >> 2);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wb_wr && adr_i == CTRL_ADDR && sel_i[0]) begin
      ctrl_q <= dat_i[CTRL_W-1:0];
    end
  end

  logic cyclic, ch16;
  assign cyclic = ctrl_q[CTRL_CYCLIC] || (VARIANT == VAR_FAST);
  assign ch16 = ctrl_q[CTRL_CH16] && (NCH > 8);

  // sequencer
  awb_state_t state_q;
  logic [3:0] cur_q;
  logic [31:0] cnt_q;
  logic [NCH-1:0] pend_q;
  logic sel_run_q;
  logic conv_wait_q;
  logic rdy_armed_q;
  logic [3:0] nch_act;
  assign nch_act = ch16 ? 4'hF : 4'h7;

  // selective request; data ignored, set wins over clear
  logic [NCH-1:0] pend_set, pend_clr;
  always_comb begin
    pend_set = '0;
    if (wb_wr && ch_hit && VARIANT != VAR_FAST && 32'(ch_idx) < NCH) begin
      pend_set[ch_idx] = 1'b1;
    end
  end

  logic any_pend;
  logic [3:0] first_pend;
  assign any_pend = |pend_q;
  always_comb begin
    first_pend = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        first_pend = 4'(i);
      end
    end
  end

  // open-wire test reach per channel-count mode
  logic wb_on;
  always_comb begin
    if (!ctrl_q[CTRL_WB_EN]) begin
      wb_on = 1'b0;
    end else if (ch16) begin
      wb_on = ctrl_q[CTRL_WB_ALL] ? 1'b1 : (cur_q < 4'h8);
    end else begin
      wb_on = ctrl_q[CTRL_WB_ALL] ? (cur_q < 4'h8) : (cur_q < 4'h4);
    end
  end

  logic test_err_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      cnt_q <= '0;
      sel_run_q <= 1'b0;
      test_err_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          test_err_q <= 1'b0;
          if (!cyclic && any_pend) begin
            cur_q <= first_pend;
            sel_run_q <= 1'b1;
            cnt_q <= '0;
            state_q <= ST_TEST;
          end else if (cyclic) begin
            sel_run_q <= 1'b0;
            cnt_q <= '0;
            state_q <= ST_TEST;
          end
        end
        ST_TEST: begin
          if (!wb_on) begin
            state_q <= ST_CONV;
          end else if (cnt_q >= 32'(TEST_CYCLES - 1)) begin
            test_err_q <= lim_s;
            state_q <= ST_CONV;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_CONV: begin
          // converter paces the conversion, so level-dependent time comes for free
          // ready only counts once it has been seen low after this start
          if (rdy_s && rdy_armed_q && !adc_start_o) begin
            state_q <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (cyclic && !sel_run_q) begin
            cur_q <= (cur_q >= nch_act) ? 4'h0 : cur_q + 4'h1;
          end
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    pend_clr = '0;
    if (state_q == ST_STORE && sel_run_q) begin
      pend_clr[cur_q] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | pend_set;
    end
  end

  // converter handshake; start waits one cycle so it never overlaps the test current
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_start_o <= 1'b0;
      conv_wait_q <= 1'b0;
      adc_chan_o <= '0;
      test_current_o <= 1'b0;
    end else begin
      adc_start_o <= (state_q == ST_CONV) && !conv_wait_q;
      conv_wait_q <= state_q == ST_CONV;
      adc_chan_o <= cur_q;
      test_current_o <= (state_q == ST_TEST) && wb_on;
    end
  end

  // ready is a level and stays high from the last result;
  // the synchroniser delays its fall, so arm only on a low seen after the start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_armed_q <= 1'b0;
    end else if (state_q != ST_CONV) begin
      rdy_armed_q <= 1'b0;
    end else if (conv_wait_q && !adc_start_o && !rdy_s) begin
      rdy_armed_q <= 1'b1;
    end
  end

  // result classification
  logic rtd, ext, any_elem;
  logic [VAL_W-1:0] val_d;
  logic err_d, ov_d;
  assign rtd = ctrl_q[CTRL_RTD_TYPE];
  assign ext = VARIANT == VAR_EXTENDED;
  assign any_elem = |elem_b_q;
  always_comb begin
    if (ctrl_q[CTRL_LIVE_ZERO]) begin
      ov_d = data_s >= LIVE_SPAN;
      val_d = ov_d ? LIVE_OFFSET + 13'(LIVE_SPAN) : LIVE_OFFSET + 13'(data_s);
    end else begin
      ov_d = ovr_s;
      val_d = 13'(data_s);
    end
    err_d = 1'b0;
    if (test_err_q) begin
      val_d = '0;
      err_d = 1'b1;
    end else if (rtd && elem_b_q[cur_q]) begin
      val_d = '0;
      err_d = ext;
    end else if (rtd && !ext && any_elem) begin
      val_d = '0;
      err_d = 1'b0;
    end else if (rtd && exc_b_q[cur_q]) begin
      val_d = '0;
      err_d = ext && ctrl_q[CTRL_SUPPLY_SW7];
    end
    // overflow flag is cleared whenever the error flag is set
    if (err_d || val_d == '0) begin
      ov_d = ov_d && !err_d;
    end
  end

  // circulating buffer of channel words
  logic [VAL_W-1:0] val_mem_q [NCH];
  logic [NCH-1:0] err_q, ov_q;
  // one flag pair per channel, each written only when its channel is stored
  for (genvar g = 0; g < NCH; g++) begin : g_flags
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        err_q[g] <= 1'b0;
        ov_q[g] <= 1'b0;
      end else if (state_q == ST_STORE && cur_q == 4'(g)) begin
        err_q[g] <= err_d;
        ov_q[g] <= ov_d;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (state_q == ST_STORE) begin
      val_mem_q[cur_q] <= val_d;
    end
  end

  // activity: module wide, not per channel
  logic act_d;
  assign act_d = any_pend || (sel_run_q && state_q != ST_IDLE);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      activity_o <= 1'b0;
    end else begin
      activity_o <= act_d;
    end
  end

  // wishbone answer: ack one cycle after request, reads registered
  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    if (ch_hit && 32'(ch_idx) < NCH) begin
      rd_d[WORD_W-1:VAL_LSB] = val_mem_q[ch_idx];
      rd_d[ACT_BIT] = activity_o;
      rd_d[ERR_BIT] = err_q[ch_idx];
      rd_d[OV_BIT] = ov_q[ch_idx];
    end else if (adr_i == CTRL_ADDR) begin
      rd_d[CTRL_W-1:0] = ctrl_q;
    end else if (adr_i == STAT_ADDR) begin
      rd_d[STAT_ACT] = activity_o;
      rd_d[STAT_CH_LSB +: 4] = cur_q;
      rd_d[STAT_PEND_LSB +: NCH] = pend_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= wb_hit;
      dat_o <= wb_hit && !we_i ? rd_d : 32'h0000_0000;
    end
  end
endmodule // awb_sampler

//--- awb_sampler_chk_asserts.sv
`timescale 1ns/1ps
module awb_sampler_chk import awb_pkg::*; (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic adc_start_o,
  input wire logic test_current_o,
  input wire logic activity_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
    else $error("start longer than one cycle");
  a_test_window: assert property ($rose(test_current_o) |->
    test_current_o [*8] ##1 !test_current_o)
    else $error("test current window length wrong");
  a_start_quiet: assert property (adc_start_o |-> !test_current_o)
    else $error("conversion started with test current on");
  a_err_zero: assert property (ack_o && $past(!we_i && adr_i < CTRL_ADDR) && dat_o[ERR_BIT]
    |-> dat_o[15:3] == 13'h0)
    else $error("error flag with nonzero value");
  a_word_upper: assert property (ack_o && $past(!we_i && adr_i < CTRL_ADDR)
    |-> dat_o[31:16] == 16'h0)
    else $error("channel word wider than 16 bits");
  cover property ($fell(activity_o));
  cover property (ack_o && dat_o[ERR_BIT]);
  cover property ($rose(test_current_o));
endmodule // awb_sampler_chk
bind awb_sampler awb_sampler_chk awb_sampler_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .dat_o, .ack_o, .adc_start_o, .test_current_o, .activity_o);

//--- awb_adc_model.sv
`timescale 1ns/1ps
module awb_adc_model #(
  parameter int DLY = 5
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // converter side
  input wire logic start_i,
  input wire logic [11:0] code_i,
  output logic ready_o,
  output logic [11:0] data_o
);
  int cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 0;
      ready_o <= 1'b0;
    end else if (start_i) begin
      cnt_q <= DLY;
      ready_o <= 1'b0;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
      ready_o <= (cnt_q == 1);
    end
  end
  // garbage while not ready, so stale data is never trusted
  assign data_o = ready_o ? code_i : ~code_i;
endmodule // awb_adc_model

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import awb_pkg::*;
  typedef struct packed {
    logic [6:0] ctrl;
    logic [3:0] ch;
    logic [11:0] code;
    logic [2:0] flt;
    logic [15:0] exp;
  } awb_row_t;
  localparam awb_row_t ROWS [7] = '{
    '{7'h1E, 4'h0, 12'h000, 3'h0, 16'h1000},
    '{7'h1E, 4'h3, 12'h7FF, 3'h0, 16'h4FF8},
    '{7'h1E, 4'h5, 12'h800, 3'h0, 16'h5001},
    '{7'h1E, 4'h7, 12'h123, 3'h4, 16'h0002},
    '{7'h1E, 4'h9, 12'h010, 3'h1, 16'h1080},
    '{7'h7E, 4'hB, 12'h010, 3'h1, 16'h0002},
    '{7'h3E, 4'hC, 12'h010, 3'h2, 16'h0002}
  };
  logic clk_i, rst_i, cyc, stb, we, ack, start, tcur, act, rdy, tol;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, dat;
  logic [3:0] chan;
  logic [11:0] code, adat;
  logic [15:0] elem, exc;
  int errors, checks_done;
  awb_sampler #(.TEST_CYCLES(8)) awb_sampler_i (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat), .ack_o(ack),
    .adc_start_o(start), .adc_chan_o(chan), .test_current_o(tcur), .adc_ready_i(rdy),
    .adc_data_i(adat), .adc_over_i(1'b0), .test_over_limit_i(tol), .elem_break_i(elem),
    .exc_break_i(exc), .activity_o(act));
  awb_adc_model awb_adc_model_i (.clk_i, .rst_i, .start_i(start), .code_i(code),
    .ready_o(rdy), .data_o(adat));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) errors++;
  endtask
  task automatic wait_act();
    logic seen;
    seen = 1'b0;
    repeat (300) begin
      @(posedge clk_i);
      if (act === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    chk({31'h0, seen}, 32'h1);
  endtask
  task print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {rst_i, cyc, stb, we, adr, wdat, code, tol, elem, exc} = '0;
    rst_i = 1'b1;
    errors = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({31'h0, act}, 32'h0);
    wb(1'b0, CTRL_ADDR, 32'h0);
    chk(rdat, 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    $display("test reset done");
    foreach (ROWS[i]) begin
      wb(1'b1, CTRL_ADDR, {25'h0, ROWS[i].ctrl});
      code <= ROWS[i].code;
      tol <= ROWS[i].flt[2];
      elem <= 16'(ROWS[i].flt[1]) << ROWS[i].ch;
      exc <= 16'(ROWS[i].flt[0]) << ROWS[i].ch;
      wb(1'b1, {2'b00, ROWS[i].ch, 2'b00}, 32'hFFFFFFFF);
      wait_act();
      wb(1'b0, {2'b00, ROWS[i].ch, 2'b00}, 32'h0);
      chk(rdat, {16'h0, ROWS[i].exp});
      chk({28'h0, chan}, {28'h0, ROWS[i].ch});
      $display("test row %0d done", i);
    end
    wb(1'b0, 8'h0C, 32'h0);
    chk(rdat, 32'h4FF8);
    wb(1'b1, 8'h80, 32'hFFFFFFFF);
    wb(1'b0, 8'h80, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, CTRL_ADDR, 32'h1E);
    code <= 12'h100;
    {tol, elem, exc} <= '0;
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'h0);
    wait_act();
    wb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h1800);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat, 32'h1800);
    $display("test awkward done");
    print_verdict();
  end
  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
endmodule // tb
